// ===== core/panel_display_controller.sv
// Panel timing, line buffer with DMA fetch, overlay blend, contrast PWM.
// Assumes one system clock; the pixel rate is an enable from a divider,
// DMA words arrive on the system clock, overlay memory answers in the same cycle as its read.
`timescale 1ns/1ps
`default_nettype none
module panel_display_controller
  import panel_display_controller_pkg::*;
#(
  parameter logic [10:0] H_ACTIVE = 11'd480,
  parameter logic [10:0] V_ACTIVE = 11'd272,
  parameter int          PIX_DIV  = 4
) (
  // Clock and reset
  input  wire logic        clk_sys_in,
  input  wire logic        rst_in,
  // Register port
  input  wire logic [7:0]  reg_addr_in,
  input  wire logic [31:0] reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic      [31:0] reg_rdata_out,
  // DMA burst request and data
  output logic             dma_req_out,
  output logic      [31:0] dma_addr_out,
  output logic      [7:0]  dma_len_out,
  input  wire logic        dma_valid_in,
  input  wire logic [31:0] dma_data_in,
  // Overlay memory read
  output logic             ov_rd_out,
  output logic      [31:0] ov_addr_out,
  input  wire logic [31:0] ov_data_in,
  // Panel
  output logic             hsync_out,
  output logic             vsync_out,
  output logic             oe_out,
  output logic      [23:0] pixel_out,
  output logic             contrast_out,
  output logic      [17:0] cursor_color_out,
  // Interrupt
  output logic             irq_out
);
  localparam int          FW = $clog2(LBUF_WORDS);
  localparam logic [19:0] FRAME_WORDS = 20'(H_ACTIVE) * 20'(V_ACTIVE);

  logic [31:0] htim_q, vtim_q, bgpan_q, pwm_q, dmac_q, ovs_q, ovvpw_q, ovpan_q;
  logic [31:0] ovst_q, ovpos_q, ovc_q, cmap_q, bgst_q;
  logic        icond_q, ien_q, istat_q, lowdep_q;
  logic [31:0] rd_mux;
  wire wr_sel = reg_wr_in;

  // Register write side
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      htim_q <= RST_ZERO; vtim_q <= RST_ZERO; bgpan_q <= RST_ZERO; pwm_q <= RST_ZERO;
      dmac_q <= RST_ZERO; ovs_q <= RST_ZERO; ovvpw_q <= RST_ZERO; ovpan_q <= RST_ZERO;
      ovst_q <= RST_ZERO; ovpos_q <= RST_ZERO; ovc_q <= RST_ZERO; cmap_q <= RST_ZERO;
      bgst_q <= RST_ZERO; icond_q <= 1'b0; ien_q <= 1'b0; lowdep_q <= 1'b0;
    end else if (wr_sel) begin
      unique case (reg_addr_in)
        OFF_HTIMING:    htim_q   <= reg_wdata_in;
        OFF_VTIMING:    vtim_q   <= reg_wdata_in;
        OFF_BG_PAN:     bgpan_q  <= reg_wdata_in;
        OFF_CONTRAST:   pwm_q    <= reg_wdata_in;
        OFF_DMA_CTRL:   dmac_q   <= reg_wdata_in;
        OFF_IRQ_COND:   icond_q  <= reg_wdata_in[0];
        OFF_IRQ_ENABLE: ien_q    <= reg_wdata_in[0];
        OFF_OV_START:   ovst_q   <= reg_wdata_in;
        OFF_OV_SIZE:    ovs_q    <= reg_wdata_in;
        OFF_OV_VPW:     ovvpw_q  <= reg_wdata_in;
        OFF_OV_PAN:     ovpan_q  <= reg_wdata_in;
        OFF_OV_POS:     ovpos_q  <= reg_wdata_in;
        OFF_OV_CTRL:    ovc_q    <= reg_wdata_in;
        OFF_CURSOR_MAP: cmap_q   <= reg_wdata_in;
        OFF_PANEL_CFG:  lowdep_q <= reg_wdata_in[0];
        OFF_BG_START:   bgst_q   <= reg_wdata_in;
        default: ;
      endcase
    end
  end

  // Pixel enable divider
  logic [7:0] div_q;
  wire        pix_en = (div_q == 8'(PIX_DIV - 1));
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) div_q <= 8'h00;
    else        div_q <= pix_en ? 8'h00 : div_q + 8'h01;
  end

  // Horizontal and vertical phase counters
  phase_t     h_st_q, v_st_q;
  logic [10:0] h_cnt_q, v_cnt_q, h_len, v_len_raw;
  wire  [10:0] hw  = {3'b000, htim_q[TIM_WIDTH_LSB +: 8]};
  wire  [10:0] hw1 = {3'b000, htim_q[TIM_WAIT1_LSB +: 8]};
  wire  [10:0] hw2 = {3'b000, htim_q[TIM_WAIT2_LSB +: 8]};
  wire  [10:0] vw  = {3'b000, vtim_q[TIM_WIDTH_LSB +: 8]};
  wire  [10:0] vw1 = {3'b000, vtim_q[TIM_WAIT1_LSB +: 8]};
  wire  [10:0] vw2 = {3'b000, vtim_q[TIM_WAIT2_LSB +: 8]};
  assign h_len = (h_st_q == PH_ACTIVE) ? H_ACTIVE :
                 (h_st_q == PH_WAIT1)  ? hw1 + H_WAIT1_ADD :
                 (h_st_q == PH_SYNC)   ? hw + H_WIDTH_ADD : hw2 + H_WAIT2_ADD;
  assign v_len_raw = (v_st_q == PH_ACTIVE) ? V_ACTIVE :
                     (v_st_q == PH_WAIT1)  ? vw1 :
                     (v_st_q == PH_SYNC)   ? vw : vw2;
  // A zero field still costs one line, the counter cannot express less
  wire [10:0] v_len  = (v_len_raw == 11'h000) ? 11'h001 : v_len_raw;
  // Shortening a field mid-phase lets the counter run on until it wraps
  wire        h_last = (h_cnt_q == h_len - 11'h001);
  wire        v_last = (v_cnt_q == v_len - 11'h001);
  wire        line_end = pix_en && h_last && (h_st_q == PH_WAIT2);
  wire        v_step = line_end && v_last;
  wire        frame_begin = v_step && (v_st_q == PH_WAIT2);
  wire        frame_end   = v_step && (v_st_q == PH_ACTIVE);

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      h_st_q <= PH_ACTIVE; h_cnt_q <= 11'h000;
      v_st_q <= PH_ACTIVE; v_cnt_q <= 11'h000;
    end else if (pix_en) begin
      h_cnt_q <= h_last ? 11'h000 : h_cnt_q + 11'h001;
      if (h_last) h_st_q <= phase_t'(h_st_q + 2'b01);
      if (line_end) begin
        v_cnt_q <= v_last ? 11'h000 : v_cnt_q + 11'h001;
        if (v_last) v_st_q <= phase_t'(v_st_q + 2'b01);
      end
    end
  end

  // Line buffer and DMA fetch
  logic [31:0]   lbuf [LBUF_WORDS];
  logic [FW-1:0] wp_q, rp_q;
  logic [FW:0]   lvl_q;
  logic [8:0]    outst_q;
  logic [19:0]   fetch_idx_q;
  wire         oe_now   = (h_st_q == PH_ACTIVE) && (v_st_q == PH_ACTIVE);
  wire         pop      = pix_en && oe_now && (lvl_q != '0);
  wire         push     = dma_valid_in && (outst_q != 9'h000);
  wire [8:0]   free_w   = 9'(LBUF_WORDS) - 9'(lvl_q) - outst_q;
  wire [8:0]   blen     = {2'b00, dmac_q[DMA_BURST_LSB +: 7]} + 9'h001;
  wire [9:0]   left_b   = {lvl_q, 2'b00};
  wire [8:0]   req_len  = dmac_q[DMA_MODE_BIT] ? blen : ((free_w < blen) ? free_w : blen);
  wire         req_go   = !dma_req_out && (outst_q == 9'h000) &&
                          (left_b <= dmac_q[DMA_TRIG_LSB +: 10]) &&
                          (dmac_q[DMA_MODE_BIT] ? (free_w >= blen) : (free_w != 9'h000));
  wire [31:0]  fetch_addr = bgst_q + {10'h000, 20'(fetch_idx_q + bgpan_q[19:0]), 2'b00};
  wire [19:0]  idx_next   = fetch_idx_q + 20'(req_len);
  always_ff @(posedge clk_sys_in) begin
    if (push) lbuf[wp_q] <= dma_data_in;
  end
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      wp_q <= '0; rp_q <= '0; lvl_q <= '0; outst_q <= 9'h000; fetch_idx_q <= 20'h0_0000;
      dma_req_out <= 1'b0; dma_addr_out <= RST_ZERO; dma_len_out <= 8'h00;
    end else begin
      if (push) wp_q <= wp_q + FW'(1);
      if (pop)  rp_q <= rp_q + FW'(1);
      lvl_q <= lvl_q + (FW+1)'(push) - (FW+1)'(pop);
      dma_req_out <= req_go;
      if (req_go) begin
        dma_addr_out <= fetch_addr;
        dma_len_out  <= 8'(req_len - 9'h001);
        fetch_idx_q  <= (idx_next >= FRAME_WORDS) ? idx_next - FRAME_WORDS : idx_next;
        outst_q      <= req_len;
      end else if (push) begin
        outst_q <= outst_q - 9'h001;
      end
    end
  end

  // Overlay window geometry
  wire [9:0]  ox  = ovpos_q[POS_X_LSB +: 10];
  wire [9:0]  oy  = ovpos_q[9:0];
  wire [9:0]  ow  = ovs_q[POS_X_LSB +: 10];
  wire [9:0]  oh  = ovs_q[9:0];
  wire [10:0] dx  = h_cnt_q - {1'b0, ox};
  wire [10:0] dy  = v_cnt_q - {1'b0, oy};
  wire        ov_hit = oe_now && (h_cnt_q >= {1'b0, ox}) && (dx < {1'b0, ow}) &&
                       (v_cnt_q >= {1'b0, oy}) && (dy < {1'b0, oh});
  wire [31:0] ov_word = 32'(dy) * 32'(ovvpw_q[10:0]) + ovpan_q + {21'h00_0000, dx};
  wire [31:0] ov_addr = ovst_q + {ov_word[29:0], 2'b00};

  // Weight 16 gives the overlay alone, so alpha 15 hides the background
  function automatic logic [7:0] mix8(input logic [7:0] f, input logic [7:0] b,
                                      input logic [4:0] wa);
    logic [12:0] s;
    s = 13'(f) * 13'(wa) + 13'(b) * (13'h0010 - 13'(wa));
    return s[11:4];
  endfunction

  // Pipeline: stage one samples timing, the next clock blends with overlay data
  logic        s1_q, oe_s1, hs_s1, vs_s1, hit_s1;
  logic [23:0] bg_s1;
  wire  [3:0]  alpha  = ovc_q[ALPHA_LSB +: 4];
  wire  [4:0]  wa     = {1'b0, alpha} + {4'h0, (alpha == 4'hF)};
  wire  [23:0] keyc   = {ovc_q[KEY_R_LSB +: 8], ovc_q[KEY_G_LSB +: 8], ovc_q[KEY_B_LSB +: 8]};
  wire         keyed  = ovc_q[CKEY_EN_BIT] && (ov_data_in[23:0] == keyc);
  wire  [23:0] blend  = {mix8(ov_data_in[23:16], bg_s1[23:16], wa),
                         mix8(ov_data_in[15:8],  bg_s1[15:8],  wa),
                         mix8(ov_data_in[7:0],   bg_s1[7:0],   wa)};
  wire  [23:0] pix_d  = !oe_s1 ? 24'h00_0000 : (hit_s1 && !keyed) ? blend : bg_s1;
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      s1_q <= 1'b0; oe_s1 <= 1'b0; hs_s1 <= 1'b0; vs_s1 <= 1'b0; hit_s1 <= 1'b0;
      bg_s1 <= 24'h00_0000; ov_rd_out <= 1'b0; ov_addr_out <= RST_ZERO;
      hsync_out <= 1'b0; vsync_out <= 1'b0; oe_out <= 1'b0; pixel_out <= 24'h00_0000;
    end else begin
      s1_q      <= pix_en;
      ov_rd_out <= pix_en && ov_hit;
      if (pix_en) begin
        oe_s1  <= oe_now;
        hs_s1  <= (h_st_q == PH_SYNC);
        vs_s1  <= (v_st_q == PH_SYNC);
        hit_s1 <= ov_hit;
        bg_s1  <= pop ? lbuf[rp_q][23:0] : 24'h00_0000;
        if (ov_hit) ov_addr_out <= ov_addr;
      end
      if (s1_q) begin
        hsync_out <= hs_s1;
        vsync_out <= vs_s1;
        oe_out    <= oe_s1;
        pixel_out <= pix_d;
      end
    end
  end

  // Contrast PWM, interrupt status, cursor colour, read port
  logic [7:0] pwm_cnt_q;
  wire        istat_clr = wr_sel && (reg_addr_in == OFF_IRQ_STATUS) && reg_wdata_in[0];
  wire        frame_evt = icond_q ? frame_begin : frame_end;
  wire [5:0]  cr = cmap_q[17:12];
  wire [5:0]  cg = cmap_q[11:6];
  wire [5:0]  cb = cmap_q[5:0];
  wire [17:0] cur_d = lowdep_q ? {cr[5:1], 1'b0, cg, cb[5:1], 1'b0} : cmap_q[17:0];
  assign rd_mux = (reg_addr_in == OFF_HTIMING)    ? htim_q :
                  (reg_addr_in == OFF_VTIMING)    ? vtim_q :
                  (reg_addr_in == OFF_BG_PAN)     ? bgpan_q :
                  (reg_addr_in == OFF_CONTRAST)   ? pwm_q :
                  (reg_addr_in == OFF_DMA_CTRL)   ? dmac_q :
                  (reg_addr_in == OFF_IRQ_COND)   ? {31'h0, icond_q} :
                  (reg_addr_in == OFF_IRQ_ENABLE) ? {31'h0, ien_q} :
                  (reg_addr_in == OFF_IRQ_STATUS) ? {31'h0, istat_q} :
                  (reg_addr_in == OFF_OV_START)   ? ovst_q :
                  (reg_addr_in == OFF_OV_SIZE)    ? ovs_q :
                  (reg_addr_in == OFF_OV_VPW)     ? ovvpw_q :
                  (reg_addr_in == OFF_OV_PAN)     ? ovpan_q :
                  (reg_addr_in == OFF_OV_POS)     ? ovpos_q :
                  (reg_addr_in == OFF_OV_CTRL)    ? ovc_q :
                  (reg_addr_in == OFF_CURSOR_MAP) ? cmap_q :
                  (reg_addr_in == OFF_PANEL_CFG)  ? {31'h0, lowdep_q} :
                  (reg_addr_in == OFF_BG_START)   ? bgst_q : RST_ZERO;
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      pwm_cnt_q <= 8'h00; contrast_out <= 1'b0; istat_q <= 1'b0; irq_out <= 1'b0;
      cursor_color_out <= 18'h0_0000; reg_rdata_out <= RST_ZERO;
    end else begin
      pwm_cnt_q <= pwm_cnt_q + 8'h01;
      contrast_out <= pwm_q[PWM_EN_BIT] && (pwm_cnt_q < pwm_q[7:0]);
      istat_q <= frame_evt | (istat_q & ~istat_clr);
      irq_out <= istat_q & ien_q;
      cursor_color_out <= cur_d;
      reg_rdata_out <= reg_rd_in ? rd_mux : RST_ZERO;
    end
  end

  chk_hsync_len: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (pix_en && h_st_q == PH_SYNC && h_last) |-> (h_cnt_q == hw))
    else $error("hsync length wrong");
  chk_hwait_one: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (pix_en && h_st_q == PH_WAIT1 && h_last) |=> (h_st_q == PH_SYNC && h_cnt_q == 11'h000))
    else $error("front wait wrong");
  chk_hwait_two: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (pix_en && h_st_q == PH_WAIT2 && h_last) |-> (h_cnt_q == hw2 + 11'h002))
    else $error("back wait wrong");
  chk_vsync_len: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (line_end && v_st_q == PH_SYNC && v_last && vw != 11'h000) |-> (v_cnt_q == vw - 11'h001))
    else $error("vsync length wrong");
  chk_irq_status: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    frame_evt |=> istat_q ##1 (irq_out == $past(ien_q)))
    else $error("frame event not recorded");
  chk_irq_gate: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (!ien_q && !$past(ien_q)) |-> !irq_out)
    else $error("irq not gated");
  chk_lbuf_level: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (lvl_q <= (FW+1)'(LBUF_WORDS)) && (9'(lvl_q) + outst_q <= 9'(LBUF_WORDS)))
    else $error("line buffer overrun");
  chk_dma_burst: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    dma_req_out |-> (outst_q == 9'(dma_len_out) + 9'h001) && $past(left_b) <= $past(dmac_q[25:16]))
    else $error("burst request wrong");
  chk_pwm_off: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    !pwm_q[PWM_EN_BIT] |=> !contrast_out)
    else $error("contrast pwm not off");
  chk_key_clear: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (s1_q && oe_s1 && hit_s1 && keyed) |=> (pixel_out == $past(bg_s1)))
    else $error("keyed pixel not transparent");
  cov_frame: cover property (@(posedge clk_sys_in) disable iff (rst_in) frame_begin);
  cov_burst: cover property (@(posedge clk_sys_in) disable iff (rst_in) dma_req_out ##1 push);
  chk_pix_blank: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    !oe_out |-> (pixel_out == 24'h00_0000))
    else $error("pixel outside enable window");
  cov_overlay: cover property (@(posedge clk_sys_in) disable iff (rst_in) ov_rd_out && !keyed);
  cov_keyed: cover property (@(posedge clk_sys_in) disable iff (rst_in) s1_q && hit_s1 && keyed);
  cov_irq: cover property (@(posedge clk_sys_in) disable iff (rst_in) irq_out);
endmodule
`default_nettype wire

// ===== include/panel_display_controller_pkg.sv
// Constants shared by the panel timing and window block.
// Assumes a 32-bit register port with byte offsets on an 8-bit address.
package panel_display_controller_pkg;
  // Register offsets
  localparam logic [7:0] OFF_HTIMING    = 8'h00;
  localparam logic [7:0] OFF_VTIMING    = 8'h04;
  localparam logic [7:0] OFF_BG_PAN     = 8'h08;
  localparam logic [7:0] OFF_CONTRAST   = 8'h0C;
  localparam logic [7:0] OFF_DMA_CTRL   = 8'h10;
  localparam logic [7:0] OFF_IRQ_COND   = 8'h14;
  localparam logic [7:0] OFF_IRQ_ENABLE = 8'h18;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h1C;
  localparam logic [7:0] OFF_OV_START   = 8'h20;
  localparam logic [7:0] OFF_OV_SIZE    = 8'h24;
  localparam logic [7:0] OFF_OV_VPW     = 8'h28;
  localparam logic [7:0] OFF_OV_PAN     = 8'h2C;
  localparam logic [7:0] OFF_OV_POS     = 8'h30;
  localparam logic [7:0] OFF_OV_CTRL    = 8'h34;
  localparam logic [7:0] OFF_CURSOR_MAP = 8'h38;
  localparam logic [7:0] OFF_PANEL_CFG  = 8'h3C;
  localparam logic [7:0] OFF_BG_START   = 8'h40;
  // Field positions (low bit of each field)
  localparam int TIM_WIDTH_LSB = 0;
  localparam int TIM_WAIT1_LSB = 8;
  localparam int TIM_WAIT2_LSB = 16;
  localparam int DMA_BURST_LSB = 0;
  localparam int DMA_TRIG_LSB  = 16;
  localparam int DMA_MODE_BIT  = 31;
  localparam int PWM_EN_BIT    = 8;
  localparam int POS_X_LSB     = 16;
  localparam int KEY_B_LSB     = 0;
  localparam int KEY_G_LSB     = 8;
  localparam int KEY_R_LSB     = 16;
  localparam int ALPHA_LSB     = 24;
  localparam int CKEY_EN_BIT   = 28;
  // Reset values
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
  // Horizontal offsets added to the programmed fields, line buffer depth, phase order
  localparam logic [10:0] H_WIDTH_ADD = 11'h001;
  localparam logic [10:0] H_WAIT1_ADD = 11'h001;
  localparam logic [10:0] H_WAIT2_ADD = 11'h003;
  localparam int          LBUF_WORDS  = 128;
  typedef enum logic [1:0] {
    PH_ACTIVE = 2'b00,
    PH_WAIT1  = 2'b01,
    PH_SYNC   = 2'b10,
    PH_WAIT2  = 2'b11
  } phase_t;
endpackage

// ===== tb/lcd_panel_model.sv
// Panel-side timing monitor: measures sync and enable intervals in clocks.
// Assumes registered, active-high sync and enable lines on the system clock.
`timescale 1ns/1ps
`default_nettype none
module lcd_panel_model (
  // Controller lines
  input  wire logic clk_sys_in,
  input  wire logic hsync_in,
  input  wire logic vsync_in,
  input  wire logic oe_in,
  // Measured intervals
  output var int    hs_width_out,
  output var int    hs_pre_out,
  output var int    hs_post_out,
  output var int    vs_width_out,
  output var int    v_blank_out
);
  int   now_q, oe_fall_q, hs_rise_q, hs_fall_q, vs_rise_q, vs_fall_q, gap1_q;
  logic hs_q = 1'b0;
  logic vs_q = 1'b0;
  logic oe_q = 1'b0;
  logic after_vs_q = 1'b0;
  always @(posedge clk_sys_in) begin
    now_q <= now_q + 1;
    hs_q  <= hsync_in;
    vs_q  <= vsync_in;
    oe_q  <= oe_in;
    if (oe_q && !oe_in) oe_fall_q <= now_q;
    if (hsync_in && !hs_q) begin
      hs_rise_q <= now_q;
      // Blank lines have no enable; keep the last in-line gap
      if (oe_fall_q > hs_fall_q) hs_pre_out <= now_q - oe_fall_q;
    end
    if (!hsync_in && hs_q) begin
      hs_width_out <= now_q - hs_rise_q;
      hs_fall_q    <= now_q;
    end
    if (oe_in && !oe_q) begin
      hs_post_out <= now_q - hs_fall_q;
      after_vs_q  <= 1'b0;
      if (after_vs_q) v_blank_out <= gap1_q + now_q - vs_fall_q;
    end
    if (vsync_in && !vs_q) begin
      vs_rise_q <= now_q;
      gap1_q    <= now_q - oe_fall_q;
    end
    if (!vsync_in && vs_q) begin
      vs_width_out <= now_q - vs_rise_q;
      vs_fall_q    <= now_q;
      after_vs_q   <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// ===== tb/panel_display_controller_bench.sv
// Self-checking bench for the panel timing and window block.
// Assumes small screen parameters; DMA and overlay memory answered here.
`timescale 1ns/1ps
`default_nettype none
module panel_display_controller_bench;
  import panel_display_controller_pkg::*;
  logic        clk_sys_in = 1'b0;
  logic        rst_in = 1'b1;
  logic [7:0]  reg_addr_in = 8'h00;
  logic [31:0] reg_wdata_in = 32'h0000_0000;
  logic        reg_wr_in = 1'b0;
  logic        reg_rd_in = 1'b0;
  logic [31:0] reg_rdata_out, dma_addr_out, ov_addr_out, d;
  logic [7:0]  dma_len_out;
  logic [8:0]  dma_left_q = 9'h000;
  logic [23:0] pixel_out;
  logic [17:0] cursor_color_out;
  logic        dma_req_out, ov_rd_out, hsync_out, vsync_out, oe_out, contrast_out, irq_out;
  int          hs_w, hs_pre, hs_post, vs_w, v_blank, error_cnt, checked, cyc, n;
  logic [31:0] ov_a [2];
  always #5 clk_sys_in = ~clk_sys_in;
  // Memory side returns every requested burst right away
  always @(posedge clk_sys_in) begin
    cyc <= cyc + 1;
    if (dma_req_out) dma_left_q <= {1'b0, dma_len_out} + 9'h001;
    else if (dma_left_q != 9'h000) dma_left_q <= dma_left_q - 9'h001;
    if (cyc == 30000) begin
      error_cnt++;
      complete_run();
    end
  end
  panel_display_controller #(.H_ACTIVE(11'd8), .V_ACTIVE(11'd4), .PIX_DIV(2)) uut (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .dma_req_out(dma_req_out), .dma_addr_out(dma_addr_out),
    .dma_len_out(dma_len_out), .dma_valid_in(dma_left_q != 9'h000),
    .dma_data_in(32'h00AB_CDEF), .ov_rd_out(ov_rd_out), .ov_addr_out(ov_addr_out),
    .ov_data_in(32'h0012_3456), .hsync_out(hsync_out), .vsync_out(vsync_out),
    .oe_out(oe_out), .pixel_out(pixel_out), .contrast_out(contrast_out),
    .cursor_color_out(cursor_color_out), .irq_out(irq_out));
  lcd_panel_model panel (
    .clk_sys_in(clk_sys_in), .hsync_in(hsync_out), .vsync_in(vsync_out), .oe_in(oe_out),
    .hs_width_out(hs_w), .hs_pre_out(hs_pre), .hs_post_out(hs_post),
    .vs_width_out(vs_w), .v_blank_out(v_blank));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys_in);
    reg_addr_in  <= a;
    reg_wdata_in <= v;
    reg_wr_in    <= 1'b1;
    @(posedge clk_sys_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys_in);
    reg_addr_in <= a;
    reg_rd_in   <= 1'b1;
    @(posedge clk_sys_in);
    reg_rd_in <= 1'b0;
    #1;
    d = reg_rdata_out;
  endtask
  // Signal select: 0 vertical sync, 1 output enable, 2 burst request
  task automatic wait_lvl(input int sel, input logic lvl);
    int i;
    for (i = 0; i < 3000; i++) begin
      @(posedge clk_sys_in);
      #1;
      if ((sel == 0 ? vsync_out : sel == 1 ? oe_out : dma_req_out) === lvl) break;
    end
    // A wait that runs out is a mismatch, not a silent pass
    if (i == 3000) begin
      error_cnt++;
      $display("[FAIL] %0t wait for signal %0d timed out", $time, sel);
    end
  endtask
  task automatic wait_rise(input int sel);
    wait_lvl(sel, 1'b0);
    wait_lvl(sel, 1'b1);
  endtask
  task automatic t_timing();
    wr(OFF_HTIMING, 32'h0005_0909);
    wr(OFF_VTIMING, 32'h0002_0203);
    rd(OFF_HTIMING);
    check(d, 32'h0005_0909);
    rd(8'h80);
    check(d, 32'h0000_0000);
    wait_rise(0);
    wait_rise(0);
    check(32'(hs_w), 32'd20);
    check(32'(hs_pre), 32'd20);
    check(32'(hs_post), 32'd16);
    wait_lvl(0, 1'b0);
    wait_rise(1);
    repeat (2) @(posedge clk_sys_in);
    // Line is 36 pixels of 2 clocks; active part is 16 clocks
    check(32'(vs_w), 32'd216);
    check(32'(v_blank), 32'd344);
  endtask
  task automatic t_irq();
    wr(OFF_IRQ_COND, 32'h0000_0000);
    wr(OFF_IRQ_ENABLE, 32'h0000_0000);
    wait_rise(0);
    wr(OFF_IRQ_STATUS, 32'h0000_0001);
    wait_rise(1);
    rd(OFF_IRQ_STATUS);
    check(d, 32'h0000_0000);
    wait_rise(0);
    rd(OFF_IRQ_STATUS);
    check(d, 32'h0000_0001);
    check({31'b0, irq_out}, 32'h0000_0000);
    wr(OFF_IRQ_ENABLE, 32'h0000_0001);
    repeat (2) @(posedge clk_sys_in);
    check({31'b0, irq_out}, 32'h0000_0001);
    wr(OFF_IRQ_STATUS, 32'h0000_0001);
    repeat (2) @(posedge clk_sys_in);
    check({31'b0, irq_out}, 32'h0000_0000);
    wr(OFF_IRQ_COND, 32'h0000_0001);
    wait_lvl(0, 1'b0);
    wr(OFF_IRQ_STATUS, 32'h0000_0001);
    rd(OFF_IRQ_STATUS);
    check(d, 32'h0000_0000);
    wait_rise(1);
    repeat (3) @(posedge clk_sys_in);
    rd(OFF_IRQ_STATUS);
    check(d, 32'h0000_0001);
    wr(OFF_IRQ_ENABLE, 32'h0000_0000);
  endtask
  task automatic t_pwm();
    for (int k = 0; k < 2; k++) begin
      wr(OFF_CONTRAST, k == 0 ? 32'h0000_0140 : 32'h0000_0040);
      repeat (2) @(posedge clk_sys_in);
      n = 0;
      // Any 256 clocks span one full period of the free counter
      repeat (256) begin
        @(posedge clk_sys_in);
        #1;
        n += int'(contrast_out);
      end
      check(32'(n), k == 0 ? 32'd64 : 32'd0);
    end
  endtask
  task automatic t_dma();
    wr(OFF_BG_START, 32'h0000_1000);
    wr(OFF_BG_PAN, 32'h0000_0040);
    wr(OFF_DMA_CTRL, 32'h8040_0003);
    wait_lvl(2, 1'b1);
    wait_rise(2);
    check({24'b0, dma_len_out}, 32'h0000_0003);
    // Index stays below one frame of words, so the pan fixes the address window
    check({31'b0, (dma_addr_out - 32'h0000_1100) < 32'h0000_0080}, 32'h0000_0001);
    wait_rise(0);
    wait_rise(1);
    repeat (3) @(posedge clk_sys_in);
    #1;
    check({8'b0, pixel_out}, 32'h00AB_CDEF);
  endtask
  task automatic t_overlay();
    logic        take;
    logic [23:0] px;
    wr(OFF_OV_START, 32'h0000_0100);
    wr(OFF_OV_PAN, 32'h0000_0003);
    wr(OFF_OV_VPW, 32'h0000_0008);
    wr(OFF_OV_SIZE, 32'h0002_0001);
    wr(OFF_OV_POS, 32'h0001_0001);
    // Pass 0 shows the overlay at full alpha, pass 1 keys its colour out
    for (int k = 0; k < 2; k++) begin
      wr(OFF_OV_CTRL, k == 0 ? 32'h0F00_0000 : 32'h1F12_3456);
      wait_rise(0);
      wait_lvl(0, 1'b0);
      n = 0;
      take = 1'b0;
      for (int i = 0; i < 3000 && vsync_out !== 1'b1; i++) begin
        @(posedge clk_sys_in);
        #1;
        // Blended pixel leaves one clock after its overlay read
        if (take) px = pixel_out;
        take = (ov_rd_out === 1'b1);
        if (take) begin
          if (n < 2) ov_a[n] = ov_addr_out;
          n++;
        end
      end
      check(32'(n), 32'd2);
      check(ov_a[0], 32'h0000_010C);
      check(ov_a[1], 32'h0000_0110);
      check({8'h00, px}, k == 0 ? 32'h0012_3456 : 32'h00AB_CDEF);
    end
  endtask
  task automatic t_cursor();
    wr(OFF_CURSOR_MAP, 32'h0003_FFFF);
    @(posedge clk_sys_in);
    #1;
    check({14'b0, cursor_color_out}, 32'h0003_FFFF);
    wr(OFF_PANEL_CFG, 32'h0000_0001);
    @(posedge clk_sys_in);
    #1;
    check({14'b0, cursor_color_out}, 32'h0003_EFFE);
  endtask
  task automatic complete_run();
    $display("mismatches %0d comparisons %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    t_timing();
    t_irq();
    t_pwm();
    t_dma();
    t_overlay();
    t_cursor();
    complete_run();
  end
endmodule
`default_nettype wire
